// >>> verilog/vpw_pkg.sv
package vpw_pkg;
  // Register and memory port geometry
  localparam int REG_AW = 4;
  localparam int REG_DW = 16;
  localparam int MEM_AW = 15;
  localparam int MEM_DW = 16;
  // Register offsets
  localparam logic [3:0] OFS_WOPT  = 4'h0;
  localparam logic [3:0] OFS_SOPT  = 4'h1;
  localparam logic [3:0] OFS_PAT   = 4'h2;
  localparam logic [3:0] OFS_MULT  = 4'h3;
  localparam logic [3:0] OFS_DIR   = 4'h4;
  localparam logic [3:0] OFS_MAJOR = 4'h5;
  localparam logic [3:0] OFS_MINOR = 4'h6;
  localparam logic [3:0] OFS_X     = 4'h7;
  localparam logic [3:0] OFS_Y     = 4'h8;
  localparam logic [3:0] OFS_EXEC  = 4'h9;
  localparam logic [3:0] OFS_STAT  = 4'hA;
  localparam logic [3:0] OFS_COUNT = 4'hB;
  // Field positions
  localparam int WO_NEG    = 0;
  localparam int WO_FN_LO  = 1;
  localparam int WO_ATT_EN = 3;
  localparam int WO_ATT_LO = 4;
  localparam int SO_REV    = 0;
  localparam int SO_RED    = 4;
  localparam int SO_BLUE   = 5;
  localparam int SO_GREEN  = 6;
  localparam int SO_BLINK  = 7;
  localparam int DIR_ARB   = 3;
  // Reset values
  localparam logic [7:0] OPT_RST  = 8'h00;
  localparam logic [3:0] MULT_RST = 4'hF;
  // Sync sequence and raster geometry
  localparam logic [3:0] SEQ_LAST   = 4'hB;
  localparam logic [3:0] SYNC_START = 4'h0;
  localparam logic [3:0] PIX_LAST   = 4'hB;
  localparam logic [9:0] X_LIN_MAX  = 10'h02FF;
  localparam logic [9:0] X_TX_MAX   = 10'h03FB;
  localparam logic [8:0] Y_MAX      = 9'h0F0;
  localparam int WORDS_PER_LINE = 64;
  localparam int LINES          = 240;
  // Modify functions
  typedef enum logic [1:0] {
    FN_OVERLAY = 2'b00,
    FN_REPLACE = 2'b01,
    FN_COMPL   = 2'b10,
    FN_ERASE   = 2'b11
  } vpw_fn_e;
  // Vector sequencer states
  typedef enum logic {
    VEC_IDLE = 1'b0,
    VEC_DRAW = 1'b1
  } vpw_vec_e;
endpackage

// >>> verilog/vpw_vector_engine.sv
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
// Function
// RULE1 - Function bits pick overlay/replace/complement/erase
// RULE2 - Negate bit inverts pattern output
// RULE3 - Bit 3 writes attribute nibble on modify
// RULE4 - Attribute nibble: blink, green, red, blue
// RULE5 - Refresh word splits into pixels and attributes
// RULE6 - Normal video: ones use latched colour
// RULE7 - Reverse video swaps colour sources
// RULE8 - Background colour from screen-option bits 6..4
// RULE9 - Twelve-step sync sequence repeats forever
// RULE10 - Select low: refresh address, high: drawing
// RULE11 - Select toggles every third step, one access
// RULE12 - Read cycle latches bank chosen by X3..X2
// RULE13 - Pending execute starts vector at sync start
// RULE14 - Raster is 240 lines of 768 pixels
// RULE15 - Basic when minor zero or equal major
// RULE16 - X 0..767, Y 0..240 from top-left
// RULE17 - X and Y step up or down after writes
// RULE18 - Host loads major and minor lengths first
// RULE19 - Eight-bit pattern shifts one bit out
// RULE20 - Pattern zero leaves pixel, except replace
// RULE21 - Multiplier count sets pattern shift rate
// RULE22 - Direction bits 2..0, bit 3 arbitrary
// RULE23 - X1..X0 choose pixel inside bank
// RULE24 - X bank bits never equal three
// RULE25 - Pixel counter decrements, zero stops run
// RULE26 - Reset clears run flip-flop
// RULE27 - Execute command sets run flip-flop
module vpw_vector_engine #(
  parameter int unsigned RASTER_WORDS = vpw_pkg::WORDS_PER_LINE * vpw_pkg::LINES
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_sys_rst,
  input  wire logic                        i_ce,
  input  wire logic [vpw_pkg::REG_AW-1:0] i_reg_addr,
  input  wire logic [vpw_pkg::REG_DW-1:0] i_reg_wdata,
  input  wire logic                        i_reg_wr,
  input  wire logic                        i_reg_rd,
  output      logic [vpw_pkg::REG_DW-1:0] o_reg_rdata,
  output      logic [vpw_pkg::MEM_AW-1:0] o_mem_addr,
  output      logic                        o_mem_ras,
  output      logic                        o_mem_cas,
  output      logic                        o_mem_we,
  output      logic [vpw_pkg::MEM_DW-1:0] o_mem_wdata,
  input  wire logic [vpw_pkg::MEM_DW-1:0] i_mem_rdata,
  output      logic                        o_draw_refresh_select,
  output      logic [2:0]                  o_video_grb,
  output      logic                        o_video_blink
);
  import vpw_pkg::*;

  logic [7:0]  write_options_reg;
  logic [7:0]  screen_options_reg;
  logic [7:0]  draw_direction_reg;
  logic [7:0]  pattern_shift_reg;
  logic [3:0]  pattern_multiplier_reg;
  logic [3:0]  mult_cnt_reg;
  logic [8:0]  major_axis_length_reg;
  logic [8:0]  minor_axis_length_reg;
  logic [8:0]  pix_cnt_reg;
  logic [9:0]  x_reg;
  logic [8:0]  y_reg;
  logic        run_flipflop_reg;
  vpw_vec_e    vec_reg;
  logic [3:0]  seq_reg;
  logic [13:0] refresh_address_counter_reg;
  logic [11:0] vid_sr_reg;
  logic [3:0]  attr_latch_reg;
  logic [3:0]  hold_reg;
  logic [15:0] word_reg;
  logic [1:0]  fr;
  logic [1:0]  ph;
  logic        wr_hit;
  logic        exec_hit;
  logic        wr_end;
  logic        basic;
  logic        x_up;
  logic        x_dn;
  logic        y_up;
  logic        y_dn;
  logic        pat_bit;
  logic        mod_bit;
  logic [3:0]  new_bank;
  logic [15:0] mod_word;
  logic [9:0]  x_lin;

  // Linear X to word/bank/pixel form
  function automatic logic [9:0] x_to_tx(input logic [9:0] lin);
    logic [9:0] l;
    logic [9:0] q;
    logic [9:0] r;
    l = (lin > X_LIN_MAX) ? X_LIN_MAX : lin;
    q = l / 10'd12;
    r = l % 10'd12;
    return {q[5:0], r[3:0]};
  endfunction

  // Frame and phase within the twelve steps
  assign fr       = 2'(seq_reg / 4'd3);
  assign ph       = 2'(seq_reg % 4'd3);
  assign wr_hit   = i_ce & i_reg_wr;
  assign exec_hit = wr_hit && (i_reg_addr == OFS_EXEC);
  assign wr_end   = (vec_reg == VEC_DRAW) && (seq_reg == SEQ_LAST);
  assign x_lin    = {x_reg[9:4], 3'b000} + {1'b0, x_reg[9:4], 2'b00} + {6'b0, x_reg[3:0]};
  // RULE15 basic test
  assign basic = (minor_axis_length_reg == 9'h000) ||
                 (minor_axis_length_reg == major_axis_length_reg);

  // Host-written option registers
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      write_options_reg      <= OPT_RST;
      screen_options_reg     <= OPT_RST;
      draw_direction_reg     <= OPT_RST;
      pattern_multiplier_reg <= MULT_RST;
      major_axis_length_reg  <= 9'h000;
      minor_axis_length_reg  <= 9'h000;
    end
    else if (wr_hit)
    begin
      unique case (i_reg_addr)
        OFS_WOPT:  write_options_reg      <= i_reg_wdata[7:0];
        OFS_SOPT:  screen_options_reg     <= i_reg_wdata[7:0];
        OFS_DIR:   draw_direction_reg     <= i_reg_wdata[7:0];
        OFS_MULT:  pattern_multiplier_reg <= i_reg_wdata[3:0];
        OFS_MAJOR: major_axis_length_reg  <= i_reg_wdata[8:0];
        OFS_MINOR: minor_axis_length_reg  <= i_reg_wdata[8:0];
        default:   ;
      endcase
    end
  end

  // Register read port, data valid one cycle only
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_reg_rdata <= 16'h0000;
    else if (i_ce)
    begin
      o_reg_rdata <= 16'h0000;
      if (i_reg_rd)
      begin
        unique case (i_reg_addr)
          OFS_X:     o_reg_rdata <= {6'b0, x_lin};
          OFS_Y:     o_reg_rdata <= {7'b0, y_reg};
          OFS_COUNT: o_reg_rdata <= {7'b0, pix_cnt_reg};
          OFS_STAT:  o_reg_rdata <= {12'b0, basic, draw_direction_reg[DIR_ARB],
                                     vec_reg == VEC_DRAW, run_flipflop_reg};
          default:   o_reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Sync sequencer, free running
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      seq_reg <= 4'h0;
    else if (i_ce)
      // RULE9 twelve-step wrap
      seq_reg <= (seq_reg == SEQ_LAST) ? 4'h0 : seq_reg + 4'h1;
  end

  // Run flip-flop; an execute beats the stop
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    // RULE26 cleared at reset
    if (i_sys_rst)
      run_flipflop_reg <= 1'b0;
    else if (i_ce)
    begin
      // RULE27 execute sets run
      if (exec_hit)
        run_flipflop_reg <= 1'b1;
      // RULE25 zero count stops
      else if (pix_cnt_reg == 9'h000)
        run_flipflop_reg <= 1'b0;
    end
  end

  // Vector sequencer and pixel down counter
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      vec_reg     <= VEC_IDLE;
      pix_cnt_reg <= 9'h000;
    end
    else if (i_ce)
    begin
      // RULE18 count taken from major length
      if (exec_hit)
        pix_cnt_reg <= major_axis_length_reg;
      // RULE25 one decrement per write
      else if (wr_end && pix_cnt_reg != 9'h000)
        pix_cnt_reg <= pix_cnt_reg - 9'h001;
      unique case (vec_reg)
        VEC_IDLE:
          // RULE13 start only at sync start
          if (seq_reg == SYNC_START && run_flipflop_reg && pix_cnt_reg != 9'h000)
            vec_reg <= VEC_DRAW;
        VEC_DRAW:
          if (wr_end && pix_cnt_reg == 9'h001 && !exec_hit)
            vec_reg <= VEC_IDLE;
      endcase
    end
  end

  // Direction decode, eight directions 45 degrees apart
  always_comb
  begin
    x_up = 1'b0;
    x_dn = 1'b0;
    y_up = 1'b0;
    y_dn = 1'b0;
    // RULE22 low three bits steer
    unique case (draw_direction_reg[2:0])
      3'h0: x_up = 1'b1;
      3'h1: begin x_up = 1'b1; y_dn = 1'b1; end
      3'h2: y_dn = 1'b1;
      3'h3: begin x_dn = 1'b1; y_dn = 1'b1; end
      3'h4: x_dn = 1'b1;
      3'h5: begin x_dn = 1'b1; y_up = 1'b1; end
      3'h6: y_up = 1'b1;
      3'h7: begin x_up = 1'b1; y_up = 1'b1; end
    endcase
  end

  // X and Y address; host load wins over stepping
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      x_reg <= 10'h000;
      y_reg <= 9'h000;
    end
    else if (i_ce)
    begin
      // RULE24 translate so bank three is skipped
      if (wr_hit && i_reg_addr == OFS_X)
        x_reg <= x_to_tx(i_reg_wdata[9:0]);
      // RULE17 step after each write
      else if (wr_end && x_up)
        x_reg <= (x_reg == X_TX_MAX) ? 10'h000 :
                 (x_reg[3:0] == 4'hB) ? {x_reg[9:4] + 6'h01, 4'h0} : x_reg + 10'h001;
      else if (wr_end && x_dn)
        x_reg <= (x_reg == 10'h000) ? X_TX_MAX :
                 (x_reg[3:0] == 4'h0) ? {x_reg[9:4] - 6'h01, 4'hB} : x_reg - 10'h001;
      // RULE16 Y wraps within 0..240
      if (wr_hit && i_reg_addr == OFS_Y)
        y_reg <= (i_reg_wdata[8:0] > Y_MAX) ? Y_MAX : i_reg_wdata[8:0];
      else if (wr_end && y_up)
        y_reg <= (y_reg == Y_MAX) ? 9'h000 : y_reg + 9'h001;
      else if (wr_end && y_dn)
        y_reg <= (y_reg == 9'h000) ? Y_MAX : y_reg - 9'h001;
    end
  end

  // Pattern register and multiplier count
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pattern_shift_reg <= 8'h00;
      mult_cnt_reg      <= MULT_RST;
    end
    else if (i_ce)
    begin
      if (wr_hit && i_reg_addr == OFS_PAT)
      begin
        pattern_shift_reg <= i_reg_wdata[7:0];
        mult_cnt_reg      <= pattern_multiplier_reg;
      end
      // RULE21 shift when count reaches all ones
      else if (wr_end && mult_cnt_reg == 4'hF)
      begin
        // RULE19 rotate so the pattern repeats
        pattern_shift_reg <= {pattern_shift_reg[6:0], pattern_shift_reg[7]};
        mult_cnt_reg      <= pattern_multiplier_reg;
      end
      else if (wr_end)
        mult_cnt_reg <= mult_cnt_reg + 4'h1;
    end
  end

  // Pixel modify logic
  always_comb
  begin
    // RULE2 negate before modify
    pat_bit = pattern_shift_reg[7] ^ write_options_reg[WO_NEG];
    // RULE23 pixel inside bank
    mod_bit = hold_reg[x_reg[1:0]];
    // RULE1 function decode
    unique case (vpw_fn_e'(write_options_reg[WO_FN_LO +: 2]))
      // RULE20 zero pattern keeps pixel
      FN_OVERLAY: mod_bit = pat_bit | mod_bit;
      FN_REPLACE: mod_bit = pat_bit;
      FN_COMPL:   mod_bit = pat_bit ^ mod_bit;
      FN_ERASE:   mod_bit = pattern_shift_reg[7] ? write_options_reg[WO_NEG] : mod_bit;
    endcase
    new_bank             = hold_reg;
    new_bank[x_reg[1:0]] = mod_bit;
    mod_word             = word_reg;
    mod_word[{x_reg[3:2], 2'b00} +: 4] = new_bank;
    // RULE3 optional attribute write
    // RULE4 nibble is blink, green, red, blue
    if (write_options_reg[WO_ATT_EN])
      mod_word[15:12] = write_options_reg[WO_ATT_LO +: 4];
  end

  // Memory strobes and address; one access per frame
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_draw_refresh_select <= 1'b0;
      o_mem_addr            <= 15'h0000;
      o_mem_ras             <= 1'b0;
      o_mem_cas             <= 1'b0;
      o_mem_we              <= 1'b0;
      o_mem_wdata           <= 16'h0000;
    end
    else if (i_ce)
    begin
      unique case (ph)
        2'h0:
        begin
          // RULE11 select toggles per three steps
          o_draw_refresh_select <= fr[0];
          // RULE10 address multiplexer
          o_mem_addr <= fr[0] ? {y_reg, x_reg[9:4]} : {1'b0, refresh_address_counter_reg};
          o_mem_ras  <= 1'b1;
          if (fr == 2'h3)
            o_mem_wdata <= mod_word;
        end
        2'h1:
        begin
          o_mem_ras <= 1'b0;
          o_mem_cas <= 1'b1;
          // RULE13 write only while drawing
          o_mem_we  <= (fr == 2'h3) && (vec_reg == VEC_DRAW);
        end
        default:
        begin
          o_mem_cas <= 1'b0;
          o_mem_we  <= 1'b0;
        end
      endcase
    end
  end

  // Drawing read: whole word plus selected bank
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      hold_reg <= 4'h0;
      word_reg <= 16'h0000;
    end
    else if (i_ce && fr == 2'h1 && ph == 2'h2 && vec_reg == VEC_DRAW)
    begin
      // RULE12 bank strobe into holding register
      hold_reg <= i_mem_rdata[{x_reg[3:2], 2'b00} +: 4];
      word_reg <= i_mem_rdata;
    end
  end

  // Refresh load and video shift; load lands every twelve clocks
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      vid_sr_reg                  <= 12'h000;
      attr_latch_reg              <= 4'h0;
      refresh_address_counter_reg <= 14'h0000;
    end
    else if (i_ce)
    begin
      if (fr == 2'h0 && ph == 2'h2)
      begin
        // RULE5 pixels to shifter, attributes to latch
        vid_sr_reg     <= i_mem_rdata[11:0];
        attr_latch_reg <= i_mem_rdata[15:12];
        // RULE14 wrap after the last visible word
        refresh_address_counter_reg <=
          (refresh_address_counter_reg == 14'(RASTER_WORDS - 1)) ? 14'h0000 :
          refresh_address_counter_reg + 14'h0001;
      end
      else
        vid_sr_reg <= {1'b0, vid_sr_reg[11:1]};
    end
  end

  // Colour select; one XOR covers normal and reverse video
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_video_grb   <= 3'b000;
      o_video_blink <= 1'b0;
    end
    else if (i_ce)
    begin
      // RULE6 shifted bit against video control
      // RULE7 reverse swaps the two sources
      if (vid_sr_reg[0] ^ screen_options_reg[SO_REV])
      begin
        o_video_grb   <= attr_latch_reg[2:0];
        o_video_blink <= attr_latch_reg[3];
      end
      else
      begin
        // RULE8 background green, red, blue
        o_video_grb   <= {screen_options_reg[SO_GREEN], screen_options_reg[SO_RED],
                          screen_options_reg[SO_BLUE]};
        o_video_blink <= screen_options_reg[SO_BLINK];
      end
    end
  end

  AST_SEQ_WRAP: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE9
    (i_ce && seq_reg == SEQ_LAST) |=> (seq_reg == 4'h0))
    else $error("sync sequence did not wrap after twelve steps");

  AST_SEL_FRAME: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE11
    (i_ce && ph == 2'h0) |=> (o_draw_refresh_select == $past(fr[0])) && o_mem_ras)
    else $error("select or row strobe wrong at frame start");

  AST_ADDR_MUX: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE10
    (o_mem_ras && !o_draw_refresh_select) |-> (o_mem_addr[14] == 1'b0))
    else $error("refresh address not routed when select is low");

  AST_WE_DRAW: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE13
    o_mem_we |-> (vec_reg == VEC_DRAW) && o_draw_refresh_select && o_mem_cas)
    else $error("memory write outside a drawing write cycle");

  AST_EXEC_SET: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE27
    exec_hit |=> run_flipflop_reg)
    else $error("execute did not set run");

  AST_START_SYNC: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE13
    $rose(vec_reg == VEC_DRAW) |-> ($past(seq_reg) == SYNC_START) && $past(run_flipflop_reg))
    else $error("vector sequencer started off the sync start step");

  AST_STOP_ZERO: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE25
    (i_ce && wr_end && pix_cnt_reg == 9'h001 && !exec_hit) |=> (vec_reg == VEC_IDLE)
    ##1 (!$past(i_ce) || $past(exec_hit) || !run_flipflop_reg))
    else $error("last write did not stop the run");

  AST_BANK_OK: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE24
    x_reg[3:2] != 2'b11)
    else $error("X bank field reached three");

  AST_ATTR_WR: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE3
    (o_mem_we && write_options_reg[WO_ATT_EN] && $stable(write_options_reg))
    |-> (o_mem_wdata[15:12] == write_options_reg[7:4]))
    else $error("attribute nibble not written");

  AST_REPLACE: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE1
    (o_mem_we && ($past(write_options_reg[2:1], 2) == FN_REPLACE)
     && ($past(x_reg, 2) == x_reg))
    |-> (o_mem_wdata[x_reg[3:0]] == $past(pat_bit, 2)))
    else $error("replace did not write the pattern");
endmodule // vpw_vector_engine

// >>> dv/vpw_mem_model.sv
`timescale 1ns/1ns
// Screen memory seen from the engine: answers only in the column strobe cycle
module vpw_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_cas,
  input  wire logic        i_we,
  input  wire logic [14:0] i_addr,
  input  wire logic [15:0] i_wdata,
  output      logic [15:0] o_rdata
);
  logic [15:0] mem [0:32767];
  logic [15:0] last_reg;

  // Off the strobe the bus shows the inverse of the last word, never a stale copy
  assign o_rdata = i_cas ? mem[i_addr] : ~last_reg;

  // Write lands at the edge that ends the strobe cycle
  always @(posedge i_clk)
  begin
    if (i_cas)
    begin
      last_reg <= mem[i_addr];
      if (i_we)
        mem[i_addr] <= i_wdata;
    end
  end

  // Blank memory so untouched words read as zero
  initial
  begin
    last_reg = 16'h0000;
    for (int i = 0; i < 32768; i++)
      mem[i] = 16'h0000;
  end
endmodule // vpw_mem_model

// >>> dv/vpw_vector_engine_tb.sv
`timescale 1ns/1ns
module vpw_vector_engine_tb;
  import vpw_pkg::*;
  logic        i_clk, i_sys_rst, i_ce, i_reg_wr, i_reg_rd, o_sel;
  logic        o_mem_ras, o_mem_cas, o_mem_we, o_video_blink, s0, p, ab, nbit;
  logic [3:0]  i_reg_addr;
  logic [15:0] i_reg_wdata, o_reg_rdata, o_mem_wdata, i_mem_rdata, old, exp_w, wo;
  logic [14:0] o_mem_addr, a;
  logic [2:0]  o_video_grb;
  logic [16:0] expq[$];
  logic [16:0] qe;
  logic [31:0] seed = 32'h0000_f995;
  logic [17:0] snap;
  logic        rd_d = 1'b0;
  int          errors, cmp_count, cyc, x, v, nr, nt, nb;

  vpw_vector_engine #(.RASTER_WORDS(8)) u_dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_mem_addr(o_mem_addr), .o_mem_ras(o_mem_ras),
    .o_mem_cas(o_mem_cas), .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata),
    .i_mem_rdata(i_mem_rdata), .o_draw_refresh_select(o_sel),
    .o_video_grb(o_video_grb), .o_video_blink(o_video_blink));

  vpw_mem_model u_mem (.i_clk(i_clk), .i_cas(o_mem_cas), .i_we(o_mem_we),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));

  // 25 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic int ddx(input int i);
    return (i == 0 || i == 1 || i == 7) ? 1 : (i >= 3 && i <= 5) ? -1 : 0;
  endfunction

  function automatic int ddy(input int i);
    return (i >= 1 && i <= 3) ? -1 : (i >= 5) ? 1 : 0;
  endfunction

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One idle cycle after each strobe, so no signal is assigned twice in a step
  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    i_reg_addr  <= ad;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    @(posedge i_clk);
  endtask

  // Read; the note goes to the queue, c=0 marks a poll that is not compared
  task automatic rd(input logic [3:0] ad, input logic [15:0] e, input logic c,
                    output logic [15:0] g);
    i_reg_addr <= ad;
    i_reg_rd   <= 1'b1;
    expq.push_back({c, e});
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 g = o_reg_rdata;
    @(posedge i_clk);
  endtask

  task automatic rc(input logic [3:0] ad, input logic [15:0] e);
    logic [15:0] g;
    rd(ad, e, 1'b1, g);
  endtask

  // Load a vector, check status, execute, poll until the run flag drops
  task automatic draw(input int xs0, ys0, len, dir, minor, st);
    logic [15:0] g;
    int n;
    wr(OFS_X, 16'(xs0));
    wr(OFS_Y, 16'(ys0));
    wr(OFS_DIR, 16'(dir));
    wr(OFS_MAJOR, 16'(len));
    wr(OFS_MINOR, 16'(minor));
    rc(OFS_STAT, 16'(st));
    wr(OFS_EXEC, 16'h0001);
    n = 0;
    g = 16'h0001;
    while (g[0] !== 1'b0 && n < 300)
    begin
      rd(OFS_STAT, 16'h0000, 1'b0, g);
      n++;
    end
    chk("run flag", 16'h0000, {15'h0000, g[0]});
    rc(OFS_COUNT, 16'h0000);
  endtask

  task automatic vid(input logic [15:0] w, input logic [7:0] so, input logic [3:0] e);
    for (int i = 0; i < 8; i++)
      u_mem.mem[i] = w;
    wr(OFS_SOPT, {8'h00, so});
    repeat (40) @(posedge i_clk);
    nb = 0;
    repeat (24)
    begin
      @(posedge i_clk);
      #1 if ({o_video_blink, o_video_grb} !== e) nb++;
    end
    chk("video colour", 16'h0000, 16'(nb));
    @(posedge i_clk);
  endtask

  // Read-data monitor and run limit
  always @(posedge i_clk)
  begin
    rd_d <= i_reg_rd;
    cyc++;
    if (cyc > 20000)
    begin
      errors++;
      final_report();
    end
    if (rd_d === 1'b1 && expq.size() > 0)
    begin
      qe = expq.pop_front();
      if (qe[16])
        chk("register read", qe[15:0], o_reg_rdata);
    end
  end

  initial
  begin
    i_sys_rst = 1'b1;
    i_ce = 1'b1;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 4'h0;
    i_reg_wdata = 16'h0000;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    // Reset state, write-only and unmapped places read zero
    rc(OFS_STAT, 16'h0008);
    rc(OFS_COUNT, 16'h0000);
    rc(OFS_X, 16'h0000);
    rc(OFS_WOPT, 16'h0000);
    wr(4'hD, 16'hFFFF);
    rc(4'hD, 16'h0000);
    $display("test reset done");
    // Coordinate limits and random readback
    wr(OFS_X, 16'd800);
    rc(OFS_X, 16'd767);
    wr(OFS_Y, 16'd300);
    rc(OFS_Y, 16'd240);
    repeat (4)
    begin
      seed = xs(seed);
      v = int'(seed % 768);
      wr(OFS_X, 16'(v));
      rc(OFS_X, 16'(v));
    end
    $display("test coordinates done");
    // Memory framing: strobes, select toggles, address source
    nr = 0;
    nt = 0;
    nb = 0;
    #1 s0 = o_sel;
    repeat (120)
    begin
      @(posedge i_clk);
      #1 nr += int'(o_mem_ras);
      if (o_sel !== s0) nt++;
      s0 = o_sel;
      if (o_mem_cas === 1'b1 && o_sel === 1'b0 && o_mem_addr >= 15'd8) nb++;
      if (o_mem_cas === 1'b1 && o_sel === 1'b1 && o_mem_addr !== {9'd240, 6'(v / 12)})
        nb++;
    end
    chk("row strobes", 16'd40, 16'(nr));
    chk("select toggles", 16'd40, 16'(nt));
    chk("bad addresses", 16'h0000, 16'(nb));
    // Clock enable low freezes the memory side
    @(posedge i_clk);
    i_ce <= 1'b0;
    @(posedge i_clk);
    #1 snap = {o_sel, o_mem_ras, o_mem_cas, o_mem_addr};
    nb = 0;
    repeat (12)
    begin
      @(posedge i_clk);
      #1 if ({o_sel, o_mem_ras, o_mem_cas, o_mem_addr} !== snap) nb++;
    end
    chk("frozen outputs", 16'h0000, 16'(nb));
    @(posedge i_clk);
    i_ce <= 1'b1;
    @(posedge i_clk);
    $display("test framing done");
    // Every function, negate and pattern bit on a random pixel
    for (int k = 0; k < 16; k++)
    begin
      seed = xs(seed);
      x = int'(seed % 768);
      a = {9'd100, 6'(x / 12)};
      seed = xs(seed);
      old = seed[15:0];
      u_mem.mem[a] = old;
      wo = {8'h00, seed[23:20], seed[24], 2'(k >> 1), k[0]};
      wr(OFS_WOPT, wo);
      wr(OFS_MULT, 16'h000F);
      wr(OFS_PAT, k[3] ? 16'h0080 : 16'h0000);
      draw(x, 100, 1, 0, 0, 8);
      p = k[3] ^ k[0];
      ab = old[x % 12];
      case (wo[2:1])
        2'b00: nbit = ab | p;
        2'b01: nbit = p;
        2'b10: nbit = ab ^ p;
        default: nbit = k[3] ? k[0] : ab;
      endcase
      exp_w = old;
      exp_w[x % 12] = nbit;
      if (wo[3])
        exp_w[15:12] = wo[7:4];
      chk("modified word", exp_w, u_mem.mem[a]);
    end
    $display("test modify done");
    // Pattern shift rate: every write, then every second write
    for (int m = 0; m < 2; m++)
    begin
      u_mem.mem[{9'd150, 6'd2}] = 16'h0000;
      wr(OFS_WOPT, 16'h0000);
      wr(OFS_MULT, m ? 16'h000E : 16'h000F);
      wr(OFS_PAT, 16'h00A0);
      draw(24, 150, 4, 0, 0, 8);
      chk("pattern word", m ? 16'h0003 : 16'h0005, u_mem.mem[{9'd150, 6'd2}]);
    end
    $display("test multiplier done");
    // All eight directions, basic and arbitrary flags
    wr(OFS_PAT, 16'h00FF);
    for (int i = 0; i < 8; i++)
    begin
      draw(400, 100, 2, {i[0], i[2:0]}, i % 3, ((i % 3 != 1) ? 8 : 0) + (i[0] ? 4 : 0));
      rc(OFS_X, 16'(400 + 2 * ddx(i)));
      rc(OFS_Y, 16'(100 + 2 * ddy(i)));
    end
    $display("test directions done");
    // Foreground and background in normal and reverse video
    vid(16'hDFFF, 8'h50, 4'b1101);
    vid(16'hDFFF, 8'hD1, 4'b1110);
    vid(16'hD000, 8'h50, 4'b0110);
    vid(16'hD000, 8'h51, 4'b1101);
    $display("test video done");
    // Reset in mid-run: run flag and pixel count must clear
    wr(OFS_MAJOR, 16'd100);
    wr(OFS_EXEC, 16'h0001);
    repeat (30) @(posedge i_clk);
    rc(OFS_STAT, 16'h0007);
    i_sys_rst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    rc(OFS_STAT, 16'h0008);
    rc(OFS_COUNT, 16'h0000);
    $display("test mid reset done");
    repeat (4) @(posedge i_clk);
    final_report();
  end
endmodule // vpw_vector_engine_tb
